/* File: pkg/ffs_pkg.sv */
// shared constants and carrier types for the sync request header and writeback framer
package ffs_pkg;

  // header field positions and count limits
  localparam int unsigned HDR_PRIM_LSB     = 0;
  localparam int unsigned HDR_SVERT_LSB    = 16;
  localparam int unsigned HDR_SPRIM_LSB    = 0;
  localparam int unsigned HDR_FIELD_W      = 16;
  localparam logic [15:0] GEOM_PRIM_MAX    = 16'h0400;
  localparam logic [15:0] STREAM_VERT_MAX  = 16'h0BFA;
  localparam logic [15:0] STREAM_PRIM_MAX  = 16'h0400;

  // writeback layout
  localparam int unsigned WB_DWORDS        = 8;
  localparam int unsigned WB_NUM_INDEX     = 4;
  localparam int unsigned WB_INDEX_DW0     = 1;
  localparam int unsigned WB_TAG_LSB       = 16;
  localparam int unsigned WB_TAG_W         = 8;
  localparam int unsigned WB_PTR_LSB       = 0;
  localparam int unsigned WB_PTR_W         = 12;

  // register byte offsets
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_POOL_BASE    = 8'h04;
  localparam logic [7:0] REG_POOL_COUNT   = 8'h08;
  localparam logic [7:0] REG_ENTRY_STRIDE = 8'h0C;
  localparam logic [7:0] REG_INDEX0       = 8'h10;
  localparam logic [7:0] REG_INDEX_STEP   = 8'h20;
  localparam logic [7:0] REG_STATUS       = 8'h24;
  localparam logic [7:0] REG_CLEAR        = 8'h28;
  localparam logic [7:0] REG_ENABLE       = 8'h2C;
  localparam logic [7:0] REG_LAST_COUNTS  = 8'h30;

  // control bits
  localparam int unsigned CTRL_AUTO_ADV   = 0;
  localparam int unsigned CTRL_GEOM_EN    = 1;
  localparam int unsigned CTRL_STREAM_EN  = 2;
  localparam int unsigned CTRL_W          = 3;

  // event bits
  localparam int unsigned EV_ACCEPT       = 0;
  localparam int unsigned EV_NO_HANDLE    = 1;
  localparam int unsigned EV_BAD_HEADER   = 2;
  localparam int unsigned EV_WB_DONE      = 3;
  localparam int unsigned EV_W            = 4;

  // reset values
  localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
  localparam logic [11:0] RST_STRIDE      = 12'h001;
  localparam logic [31:0] RST_STEP        = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] dw1;
    logic [31:0] dw0;
  } ffs_hdr_t;

  typedef struct packed {
    logic [15:0] geom_prim_count;
    logic [15:0] stream_vertex_count;
    logic [15:0] stream_prim_count;
  } ffs_counts_t;

  typedef struct packed {
    logic                handle_valid;
    logic [WB_TAG_W-1:0] entry_link_tag;
    logic [WB_PTR_W-1:0] first_entry_pointer;
  } ffs_handle_t;

  typedef logic [WB_DWORDS-1:0][31:0] ffs_wb_t;
  typedef logic [WB_NUM_INDEX-1:0][31:0] ffs_index_t;

endpackage : ffs_pkg

/* File: src/ffs_hdr_decode.sv */
// header field extraction and range checking for sync requests
`timescale 1ns/10ps
module ffs_hdr_decode
  import ffs_pkg::*;
(
  // header in
  input  wire ffs_pkg::ffs_hdr_t    hdr_i,
  input  wire logic                 geom_en_i,
  input  wire logic                 stream_en_i,
  input  wire logic                 auto_adv_i,
  // decoded out
  output      ffs_pkg::ffs_counts_t counts_o,
  output      logic                 bad_o
);
  import ffs_pkg::*;

  function automatic logic over(input logic [15:0] v, input logic [15:0] lim);
    over = v > lim;
  endfunction : over

  wire logic [15:0] raw_prim  = hdr_i.dw1[HDR_PRIM_LSB +: HDR_FIELD_W];
  wire logic [15:0] raw_svert = hdr_i.dw0[HDR_SVERT_LSB +: HDR_FIELD_W];
  wire logic [15:0] raw_sprim = hdr_i.dw0[HDR_SPRIM_LSB +: HDR_FIELD_W];

  // out-of-range or nonzero-while-disabled counts flag a malformed header
  wire logic bad_prim   = over(raw_prim, GEOM_PRIM_MAX) | (!geom_en_i && raw_prim != 16'h0000);
  wire logic bad_stream = over(raw_svert, STREAM_VERT_MAX) | over(raw_sprim, STREAM_PRIM_MAX)
                        | (!stream_en_i && (raw_svert != 16'h0000 || raw_sprim != 16'h0000));
  // stream counts are dropped when the unit advances indices itself
  wire logic stream_used = !auto_adv_i;

  assign counts_o.geom_prim_count     = raw_prim;
  assign counts_o.stream_vertex_count = stream_used ? raw_svert : 16'h0000;
  assign counts_o.stream_prim_count   = stream_used ? raw_sprim : 16'h0000;
  assign bad_o = bad_prim | (stream_used & bad_stream);

endmodule : ffs_hdr_decode

/* File: src/ffs_wb_pack.sv */
// assembles the eight-dword writeback from handle info and stream indices
`timescale 1ns/10ps
module ffs_wb_pack
  import ffs_pkg::*;
(
  // sources
  input  wire ffs_pkg::ffs_handle_t handle_i,
  input  wire ffs_pkg::ffs_index_t  index_i,
  input  wire logic                 is_geom_i,
  // packed writeback
  output      ffs_pkg::ffs_wb_t     wb_o
);
  import ffs_pkg::*;

  wire logic [31:0] dw0 = {8'h00,
                           handle_i.entry_link_tag,
                           4'h0,
                           handle_i.first_entry_pointer};

  always_comb
  begin
    wb_o    = '0;
    wb_o[0] = handle_i.handle_valid ? dw0 : 32'h0000_0000;
    // clip threads get zeros beyond dword 0
    for (int i = 0; i < WB_NUM_INDEX; i++)
    begin
      if (is_geom_i)
      begin
        wb_o[WB_INDEX_DW0 + i] = index_i[i];
      end
    end
  end

endmodule : ffs_wb_pack

/* File: src/ffs_sync_unit.sv */
// sync request framer: header decode, handle allocation, writeback and wishbone registers
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module ffs_sync_unit
  import ffs_pkg::*;
#(
  parameter int unsigned POOL_W = 8
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  // sync request from thread
  input  wire logic              req_valid_i,
  input  wire logic              req_is_geom_i,
  input  wire ffs_pkg::ffs_hdr_t req_hdr_i,
  output      logic              req_ready_o,
  // writeback to thread
  output      logic              wbk_valid_o,
  output      logic              wbk_handle_valid_o,
  output      logic              wbk_is_geom_o,
  output      ffs_pkg::ffs_wb_t  wbk_data_o,
  input  wire logic              wbk_ready_i,
  // interrupt
  output      logic              irq_o
);
  import ffs_pkg::*;

  if (POOL_W < 1 || POOL_W > 32)
  begin : g_chk
    $error("POOL_W must be 1..32");
  end

  typedef enum logic [1:0] {
    FFS_IDLE = 2'b01,
    FFS_SEND = 2'b10
  } ffs_state_t;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
    begin
      lane_merge[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction : lane_merge

  ffs_state_t           state_reg;
  logic [CTRL_W-1:0]    ctrl_reg;
  logic [WB_PTR_W-1:0]  alloc_ptr_reg;
  logic [POOL_W-1:0]    pool_count_reg;
  logic [WB_PTR_W-1:0]  stride_reg;
  ffs_index_t           index_reg;
  logic [31:0]          step_reg;
  logic [EV_W-1:0]      status_reg;
  logic [EV_W-1:0]      enable_reg;
  logic [WB_TAG_W-1:0]  tag_reg;
  ffs_counts_t          last_counts_reg;
  logic [31:0]          rdata_reg;
  logic                 ack_reg;
  logic                 ready_reg;
  logic                 wbk_valid_reg;
  logic                 wbk_hv_reg;
  logic                 wbk_geom_reg;
  ffs_wb_t              wbk_data_reg;
  logic                 irq_reg;

  // bus decode
  wire logic        bus_req   = wb_cyc_i & wb_stb_i & !ack_reg;
  wire logic        bus_wr    = bus_req & wb_we_i;
  wire logic        wr_ctrl   = bus_wr && wb_adr_i == REG_CTRL;
  wire logic        wr_base   = bus_wr && wb_adr_i == REG_POOL_BASE;
  wire logic        wr_count  = bus_wr && wb_adr_i == REG_POOL_COUNT;
  wire logic        wr_stride = bus_wr && wb_adr_i == REG_ENTRY_STRIDE;
  wire logic        wr_step   = bus_wr && wb_adr_i == REG_INDEX_STEP;
  wire logic        wr_clear  = bus_wr && wb_adr_i == REG_CLEAR;
  wire logic        wr_enable = bus_wr && wb_adr_i == REG_ENABLE;
  wire logic [5:0]  idx_off   = 6'(wb_adr_i - REG_INDEX0);
  wire logic        in_index  = wb_adr_i >= REG_INDEX0 && wb_adr_i < REG_INDEX_STEP
                                && wb_adr_i[1:0] == 2'b00;
  wire logic [1:0]  idx_sel   = idx_off[3:2];
  // lane-merged write values, narrowed per register where they land
  wire logic [31:0] ctrl_wr   = lane_merge(32'(ctrl_reg), wb_dat_i, wb_sel_i);
  wire logic [31:0] stride_wr = lane_merge(32'(stride_reg), wb_dat_i, wb_sel_i);
  wire logic [31:0] enable_wr = lane_merge(32'(enable_reg), wb_dat_i, wb_sel_i);
  wire logic [31:0] base_wr   = lane_merge(32'(alloc_ptr_reg), wb_dat_i, wb_sel_i);
  wire logic [31:0] count_wr  = lane_merge(32'(pool_count_reg), wb_dat_i, wb_sel_i);

  // request handling
  wire logic        auto_adv  = ctrl_reg[CTRL_AUTO_ADV];
  wire logic        geom_en   = ctrl_reg[CTRL_GEOM_EN];
  wire logic        stream_en = ctrl_reg[CTRL_STREAM_EN];
  wire logic        accept    = state_reg == FFS_IDLE && req_valid_i;
  wire logic        done      = state_reg == FFS_SEND && wbk_ready_i;
  wire logic        have_hdl  = pool_count_reg != '0;
  ffs_counts_t      counts;
  logic             bad_hdr;
  ffs_handle_t      handle;
  ffs_wb_t          wb_frame;

  ffs_hdr_decode u_decode (
    .hdr_i       (req_hdr_i),
    .geom_en_i   (geom_en),
    .stream_en_i (stream_en),
    .auto_adv_i  (auto_adv),
    .counts_o    (counts),
    .bad_o       (bad_hdr)
  );

  // a handle is offered only while the pool holds one
  assign handle.handle_valid        = have_hdl;
  assign handle.entry_link_tag      = have_hdl ? tag_reg : '0;
  assign handle.first_entry_pointer = have_hdl ? alloc_ptr_reg : '0;

  ffs_wb_pack u_pack (
    .handle_i  (handle),
    .index_i   (index_reg),
    .is_geom_i (req_is_geom_i),
    .wb_o      (wb_frame)
  );

  // indices advance after being handed out; auto-advance uses the step register
  wire logic        adv_en   = accept & req_is_geom_i & stream_en;
  wire logic [31:0] adv_amt  = auto_adv ? step_reg
                                        : {16'h0000, counts.stream_vertex_count};

  // events and sticky status, set beats clear
  wire logic [EV_W-1:0] events = {done,
                                  accept & bad_hdr,
                                  accept & !have_hdl,
                                  accept};
  wire logic [EV_W-1:0] clr_bits = wr_clear ? wb_dat_i[EV_W-1:0] & {EV_W{wb_sel_i[0]}}
                                            : '0;
  wire logic [EV_W-1:0] status_next = (status_reg & ~clr_bits) | events;

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (in_index)
    begin
      rd_mux = index_reg[idx_sel];
    end
    else
    begin
      unique case (wb_adr_i)
        REG_CTRL:         rd_mux = 32'(ctrl_reg);
        REG_POOL_BASE:    rd_mux = 32'(alloc_ptr_reg);
        REG_POOL_COUNT:   rd_mux = 32'(pool_count_reg);
        REG_ENTRY_STRIDE: rd_mux = 32'(stride_reg);
        REG_INDEX_STEP:   rd_mux = step_reg;
        REG_STATUS:       rd_mux = 32'(status_reg);
        REG_ENABLE:       rd_mux = 32'(enable_reg);
        REG_LAST_COUNTS:  rd_mux = {last_counts_reg.stream_vertex_count,
                                    last_counts_reg.geom_prim_count};
        default:          rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // bus slave and interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= RST_ZERO;
      irq_reg   <= 1'b0;
    end
    else
    begin
      ack_reg   <= bus_req;
      rdata_reg <= bus_req && !wb_we_i ? rd_mux : RST_ZERO;
      irq_reg   <= |(status_next & enable_reg);
    end
  end

  // software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg   <= '0;
      stride_reg <= RST_STRIDE;
      step_reg   <= RST_STEP;
      enable_reg <= '0;
      status_reg <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= ctrl_wr[CTRL_W-1:0];
      if (wr_stride)
        stride_reg <= stride_wr[WB_PTR_W-1:0];
      if (wr_step)
        step_reg <= lane_merge(step_reg, wb_dat_i, wb_sel_i);
      if (wr_enable)
        enable_reg <= enable_wr[EV_W-1:0];
      status_reg <= status_next;
    end
  end

  // handle pool: software refill wins over an allocation in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alloc_ptr_reg  <= '0;
      pool_count_reg <= '0;
      tag_reg        <= '0;
    end
    else
    begin
      if (wr_base)
        alloc_ptr_reg <= base_wr[WB_PTR_W-1:0];
      else if (accept && have_hdl)
        alloc_ptr_reg <= alloc_ptr_reg + stride_reg;
      if (wr_count)
        pool_count_reg <= count_wr[POOL_W-1:0];
      else if (accept && have_hdl)
        pool_count_reg <= pool_count_reg - 1'b1;
      if (accept && have_hdl)
        tag_reg <= tag_reg + 1'b1;
    end
  end

  // stream buffer start indices
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      index_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < WB_NUM_INDEX; i++)
      begin
        if (bus_wr && in_index && idx_sel == 2'(i))
          index_reg[i] <= lane_merge(index_reg[i], wb_dat_i, wb_sel_i);
        else if (adv_en)
          index_reg[i] <= index_reg[i] + adv_amt;
      end
    end
  end

  // request / writeback sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg       <= FFS_IDLE;
      ready_reg       <= 1'b1;
      wbk_valid_reg   <= 1'b0;
      wbk_hv_reg      <= 1'b0;
      wbk_geom_reg    <= 1'b0;
      wbk_data_reg    <= '0;
      last_counts_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        FFS_IDLE:
        begin
          if (req_valid_i)
          begin
            state_reg       <= FFS_SEND;
            ready_reg       <= 1'b0;
            wbk_valid_reg   <= 1'b1;
            wbk_hv_reg      <= have_hdl;
            wbk_geom_reg    <= req_is_geom_i;
            wbk_data_reg    <= wb_frame;
            last_counts_reg <= counts;
          end
        end
        FFS_SEND:
        begin
          if (wbk_ready_i)
          begin
            state_reg     <= FFS_IDLE;
            ready_reg     <= 1'b1;
            wbk_valid_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = rdata_reg;
  assign req_ready_o        = ready_reg;
  assign wbk_valid_o        = wbk_valid_reg;
  assign wbk_handle_valid_o = wbk_hv_reg;
  assign wbk_is_geom_o      = wbk_geom_reg;
  assign wbk_data_o         = wbk_data_reg;
  assign irq_o              = irq_reg;

endmodule : ffs_sync_unit

/* File: verification/ffs_sync_unit_asserts.sv */
// port assertions for the sync request framer
`timescale 1ns/10ps
module ffs_sync_unit_asserts
  import ffs_pkg::*;
(
  // clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // wishbone
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // request and writeback
  input wire logic             req_valid_i,
  input wire logic             req_is_geom_i,
  input wire logic             req_ready_o,
  input wire logic             wbk_valid_o,
  input wire logic             wbk_handle_valid_o,
  input wire logic             wbk_is_geom_o,
  input wire ffs_pkg::ffs_wb_t wbk_data_o,
  input wire logic             wbk_ready_i
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_take;
    req_valid_i && req_ready_o |=> wbk_valid_o && !req_ready_o;
  endproperty
  a_take: assert property (p_take) else $error("take gave no writeback");
  property p_kind;
    req_valid_i && req_ready_o |=> wbk_is_geom_o == $past(req_is_geom_i);
  endproperty
  a_kind: assert property (p_kind) else $error("thread kind lost");
  property p_hold;
    wbk_valid_o && !wbk_ready_i |=>
      wbk_valid_o && $stable(wbk_data_o) && $stable(wbk_handle_valid_o);
  endproperty
  a_hold: assert property (p_hold) else $error("writeback moved");
  property p_done;
    wbk_valid_o && wbk_ready_i |=> !wbk_valid_o && req_ready_o;
  endproperty
  a_done: assert property (p_done) else $error("writeback not retired");
  property p_resv;
    wbk_valid_o |-> wbk_data_o[0][31:24] == 8'h00 && wbk_data_o[0][15:12] == 4'h0
      && wbk_data_o[7:5] == '0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_nohdl;
    wbk_valid_o && !wbk_handle_valid_o |-> wbk_data_o[0] == 32'h0000_0000;
  endproperty
  a_nohdl: assert property (p_nohdl) else $error("stale handle");
  property p_clip;
    wbk_valid_o && !wbk_is_geom_o |-> wbk_data_o[4:1] == '0;
  endproperty
  a_clip: assert property (p_clip) else $error("clip got indices");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bad ack timing");
  property p_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside ack");

  c_hv: cover property (wbk_valid_o && wbk_handle_valid_o && wbk_is_geom_o);
  c_nohdl: cover property (wbk_valid_o && !wbk_handle_valid_o);
  c_stall: cover property ((wbk_valid_o && !wbk_ready_i) [*3]);
endmodule : ffs_sync_unit_asserts

bind ffs_sync_unit ffs_sync_unit_asserts u_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .req_valid_i, .req_is_geom_i, .req_ready_o, .wbk_valid_o,
  .wbk_handle_valid_o, .wbk_is_geom_o, .wbk_data_o, .wbk_ready_i
);

/* File: verification/ffs_thread_model.sv */
// shader thread model issuing sync requests and taking writebacks
`timescale 1ns/10ps
module ffs_thread_model
  import ffs_pkg::*;
(
  // clock
  input  wire logic             clk_i,
  // from the unit
  input  wire logic             ready_i,
  input  wire logic             wbk_valid_i,
  input  wire logic             wbk_hv_i,
  input  wire ffs_pkg::ffs_wb_t wbk_data_i,
  // to the unit
  output      logic             req_valid_o,
  output      logic             req_is_geom_o,
  output      ffs_pkg::ffs_hdr_t req_hdr_o,
  output      logic             wbk_ready_o,
  // captured writeback
  output      ffs_pkg::ffs_wb_t got_o,
  output      logic             got_hv_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_is_geom_o = 1'b0;
    req_hdr_o = '0;
    wbk_ready_o = 1'b0;
  end

  task automatic send(input logic geom, input logic [15:0] gp, input logic [15:0] sv,
                      input logic [15:0] sp, input int stall);
    req_is_geom_o <= geom;
    req_hdr_o     <= {16'h0000, gp, sv, sp};
    req_valid_o   <= 1'b1;
    do @(posedge clk_i); while (!ready_i);
    // released lines must not keep looking valid
    req_valid_o   <= 1'b0;
    req_hdr_o     <= ~req_hdr_o;
    req_is_geom_o <= ~geom;
    do @(posedge clk_i); while (!wbk_valid_i);
    repeat (stall) @(posedge clk_i);
    wbk_ready_o <= 1'b1;
    @(posedge clk_i);
    got_o = wbk_data_i; // indices used only when streaming
    got_hv_o = wbk_hv_i; // no handle means a buffer write follows
    wbk_ready_o <= 1'b0;
    @(posedge clk_i);
  endtask : send
endmodule : ffs_thread_model

/* File: verification/sync_request_message_header_writeback_test.sv */
// self-checking bench for the sync request framer
`timescale 1ns/10ps
module sync_request_message_header_writeback_test;
  import ffs_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        req_valid_i, req_is_geom_i, req_ready_o, wbk_ready_i;
  logic        wbk_valid_o, wbk_handle_valid_o, wbk_is_geom_o, got_hv;
  ffs_hdr_t    req_hdr_i;
  ffs_wb_t     wbk_data_o, got;
  logic [7:0]  tag0;
  int          n_fail = 0;
  int          checks_done = 0;

  ffs_sync_unit dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_is_geom_i, .req_hdr_i,
    .req_ready_o, .wbk_valid_o, .wbk_handle_valid_o, .wbk_is_geom_o,
    .wbk_data_o, .wbk_ready_i, .irq_o
  );
  ffs_thread_model u_thr (
    .clk_i, .ready_i(req_ready_o), .wbk_valid_i(wbk_valid_o),
    .wbk_hv_i(wbk_handle_valid_o), .wbk_data_i(wbk_data_o),
    .req_valid_o(req_valid_i), .req_is_geom_o(req_is_geom_i),
    .req_hdr_o(req_hdr_i), .wbk_ready_o(wbk_ready_i), .got_o(got), .got_hv_o(got_hv)
  );

  task automatic finish_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // no local limit: only the watchdog ends a stuck access
    do @(posedge clk_i); while (!wb_ack_o);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_io

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_io(1'b0, a, ~e, q);
    check(q, e);
  endtask : rc

  task automatic t_reset();
    rc(REG_CTRL, RST_ZERO);
    rc(REG_ENTRY_STRIDE, {20'h00000, RST_STRIDE});
    rc(REG_INDEX_STEP, RST_STEP);
    rc(REG_STATUS, RST_ZERO);
    wr(8'h40, 32'hFFFF_FFFF);
    rc(8'h40, RST_ZERO);
    rc(REG_CLEAR, RST_ZERO);
  endtask : t_reset

  // maxima of every field are still legal, with a slow reader
  task automatic t_geom();
    wr(REG_POOL_BASE, 32'h0000_0123);
    wr(REG_POOL_COUNT, 32'h0000_0002);
    wr(REG_ENTRY_STRIDE, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0006);
    for (int i = 0; i < 4; i++)
      wr(REG_INDEX0 + 8'(4 * i), 32'h100 * (i + 1));
    u_thr.send(1'b1, GEOM_PRIM_MAX, STREAM_VERT_MAX, STREAM_PRIM_MAX, 3);
    check({31'h0, got_hv}, 32'h1);
    check({31'h0, wbk_is_geom_o}, 32'h1);
    check({20'h0, got[0][11:0]}, 32'h123);
    check(got[0] & 32'hFF00_F000, 32'h0);
    for (int i = 1; i < 5; i++)
      check(got[i], 32'h100 * i);
    for (int i = 5; i < 8; i++)
      check(got[i], 32'h0);
    tag0 = got[0][23:16];
    rc(REG_LAST_COUNTS, {STREAM_VERT_MAX, GEOM_PRIM_MAX});
    rc(REG_INDEX0, 32'h100 + 32'h0BFA);
    rc(REG_STATUS, 32'h0000_0009);
  endtask : t_geom

  // auto-advance: absurd stream counts must be ignored
  task automatic t_auto();
    wr(REG_INDEX_STEP, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0007);
    u_thr.send(1'b1, 16'h0001, 16'hFFFF, 16'hFFFF, 0);
    check({20'h0, got[0][11:0]}, 32'h127);
    check({24'h0, got[0][23:16]}, {24'h0, tag0 + 8'h01});
    check(got[1], 32'h100 + 32'h0BFA);
    rc(REG_INDEX0, 32'h100 + 32'h0BFA + 32'h5);
    rc(REG_LAST_COUNTS, 32'h0000_0001);
    rc(REG_STATUS, 32'h0000_0009);
  endtask : t_auto

  // pool now empty: clip thread gets no handle and an all-zero writeback
  task automatic t_nohdl();
    u_thr.send(1'b0, 16'h0000, 16'h0000, 16'h0000, 1);
    check({31'h0, got_hv}, 32'h0);
    check({31'h0, wbk_is_geom_o}, 32'h0);
    for (int i = 0; i < 8; i++)
      check(got[i], 32'h0);
    rc(REG_STATUS, 32'h0000_000B);
  endtask : t_nohdl

  task automatic t_irq();
    wr(REG_ENABLE, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0);
    wr(REG_ENABLE, 32'h0000_0002);
    check({31'h0, irq_o}, 32'h1);
    wr(REG_CLEAR, 32'h0000_0002);
    rc(REG_STATUS, 32'h0000_0009);
    check({31'h0, irq_o}, 32'h0);
    wr(REG_ENABLE, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_POOL_COUNT, 32'h0000_0001);
    u_thr.send(1'b1, 16'h0001, 16'h0000, 16'h0000, 0);
    rc(REG_STATUS, 32'h0000_000D);
    check({31'h0, irq_o}, 32'h1);
    wr(REG_CLEAR, 32'h0000_000F);
    rc(REG_STATUS, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0);
  endtask : t_irq

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (4000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end

  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_geom();
    t_auto();
    t_nohdl();
    t_irq();
    finish_test();
  end
endmodule : sync_request_message_header_writeback_test
